// ===== dv/sflash_regs_tb_top.sv
// Self-checking bench of the serial flash register group
`include "flash_regs_defs.svh"

module sflash_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int UNITS = 16;     // Status units seen by reads
  logic        mclk, rst_n, hw_rst_n, sw_reset;
  logic        erase_susp, prog_susp, four_byte, go;
  logic [47:0] ecc_flags;        // Per-unit flag triplets
  logic [7:0]  addr_upper, boot_delay, b;
  logic [31:0] boot_addr, rx_word, seed, word, a;
  logic        sck, cs_n, mosi, miso, miso_oe, rx_toggle;
  logic [63:0] exp_q[$];         // Notes of {mask, expected}
  logic [63:0] note;
  int          miscompares, n_tests;

  sflash_regs #(.ECC_UNITS(UNITS), .DENSITY_256(1'b1)) uut (
    .mclk_i(mclk), .rst_n_i(rst_n), .hw_rst_n_i(hw_rst_n),
    .sw_reset_i(sw_reset), .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .erase_suspended_i(erase_susp),
    .program_suspended_i(prog_susp), .ecc_flags_i(ecc_flags),
    .addr_upper_o(addr_upper), .four_byte_addr_enable_o(four_byte),
    .boot_fetch_go_o(go), .boot_start_addr_o(boot_addr),
    .boot_start_delay_o(boot_delay));

  spi_host_model host (
    .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
    .miso_oe_i(miso_oe), .rx_word_o(rx_word), .rx_toggle_o(rx_toggle));

  // Core clock, 4 ns period
  always #2 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Note the expected read word, then send the frame
  task automatic run(input logic [39:0] tx, input int ntx, input int nrx,
                     input logic [31:0] exp, input logic [31:0] mask);
    if (nrx > 0) exp_q.push_back({mask, exp});
    host.frame(tx, ntx, nrx);
  endtask

  // Watch a bounded window for the boot fetch start pulse
  task automatic expect_go(input logic want);
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(posedge mclk);
      #1;
      if (go === 1'b1) seen = 1'b1;
    end
    check(32'(seen), 32'(want));
  endtask

  task automatic test_done;
    if (exp_q.size() != 0) miscompares++;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Oldest note is compared with each read payload
  always @(rx_toggle) begin
    if ($time > 0) begin
      if (exp_q.size() == 0) check(rx_word, 32'hFFFF_FFFF);
      else begin
        note = exp_q.pop_front();
        check(rx_word & note[63:32], note[31:0]);
      end
    end
  end

  // Hang guard
  initial begin
    #200000;
    miscompares++;
    test_done;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    hw_rst_n = 1'b1;
    sw_reset = 1'b0;
    erase_susp = 1'b0;
    prog_susp = 1'b0;
    ecc_flags = '0;
    seed = 32'h2F08;
    miscompares = 0;
    n_tests = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    // Reset values of status two, boot config and bank registers
    run({`CMD_READ_STATUS_TWO, 32'h0}, 8, 8, 32'h0, 32'hFF);
    run({`CMD_BOOT_CFG_READ, 32'h0}, 8, 32, 32'h0, '1);
    run({`CMD_BANK_READ, 32'h0}, 8, 8, 32'h0, 32'hFF);
    // Every suspend combination, after an attempted register write
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      erase_susp <= k[1];
      prog_susp <= k[0];
      run({`CMD_WRITE_REGS, 8'hFF, 24'h0}, 16, 0, 0, 0);
      run({`CMD_READ_STATUS_TWO, 32'h0}, 8, 8, 32'(k), 32'hFF);
    end
    // Boot-fetch word written and read back, fields at the outputs
    seed = lfsr(seed);
    word = seed | 32'h1;
    run({`CMD_BOOT_CFG_WRITE, word}, 40, 0, 0, 0);
    run({`CMD_BOOT_CFG_READ, 32'h0}, 8, 32, word, '1);
    @(posedge mclk);
    #1;
    check(boot_addr, {word[31:9], 9'h0});
    check(32'(boot_delay), 32'(word[8:1]));
    // Bank writes by both routes, both address modes
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      b = {k[0], seed[6:0]};
      if (k[1]) begin
        run({`CMD_BANK_ACCESS, 32'h0}, 8, 0, 0, 0);
        run({`CMD_WRITE_REGS, b, 24'h0}, 16, 0, 0, 0);
      end else begin
        run({`CMD_BANK_WRITE, b, 24'h0}, 16, 0, 0, 0);
      end
      run({`CMD_BANK_READ, 32'h0}, 8, 8, {b[7], 6'h0, b[0]}, 'hFF);
      @(posedge mclk);
      #1;
      check(32'(four_byte), 32'(b[7]));
      check(32'(addr_upper), b[7] ? 32'h0 : 32'(b[0]));
    end
    // Unit status reads, four-byte address first, then three-byte
    for (int m = 0; m < 2; m++) begin
      if (m == 1) run({`CMD_BANK_WRITE, 8'h00, 24'h0}, 16, 0, 0, 0);
      @(posedge mclk);
      seed = lfsr(seed);
      ecc_flags <= {seed[15:0], lfsr(seed)};
      @(posedge mclk);
      for (int u = 0; u < UNITS; u++) begin
        a = {seed[31:8], 4'(u), seed[3:0]};
        if (m == 0) run({`CMD_ECC_STATUS_READ, a}, 40, 8,
          32'(ecc_flags[3*u +: 3]), 32'h7);
        else run({`CMD_ECC_STATUS_READ, a[23:0], 8'h0}, 32, 8,
          32'(ecc_flags[3*u +: 3]), 32'h7);
      end
    end
    // Software reset with fetch enabled: bank cleared, word kept
    run({`CMD_BANK_WRITE, 8'h81, 24'h0}, 16, 0, 0, 0);
    @(posedge mclk);
    sw_reset <= 1'b1;
    @(posedge mclk);
    sw_reset <= 1'b0;
    expect_go(1'b1);
    run({`CMD_BANK_READ, 32'h0}, 8, 8, 32'h0, 32'hFF);
    run({`CMD_BOOT_CFG_READ, 32'h0}, 8, 32, word, '1);
    // Hardware reset with fetch disabled
    run({`CMD_BANK_WRITE, 8'h80, 24'h0}, 16, 0, 0, 0);
    run({`CMD_BOOT_CFG_WRITE, word & ~32'h1}, 40, 0, 0, 0);
    @(posedge mclk);
    hw_rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    hw_rst_n <= 1'b1;
    expect_go(1'b0);
    check(32'(four_byte), 32'h0);
    run({`CMD_BANK_READ, 32'h0}, 8, 8, 32'h0, 32'hFF);
    for (int i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge mclk);
    test_done;
  end
endmodule

// ===== dv/spi_host_model.sv
// Mode-0 serial host model that frames register commands for the block
module spi_host_model (
  output logic        sck_o,       // Link clock, low outside frames
  output logic        cs_n_o,      // Frame select, active low
  output logic        mosi_o,      // Command and write data
  input  wire logic   miso_i,      // Read data from the device
  input  wire logic   miso_oe_i,   // Device drives read data
  output logic [31:0] rx_word_o,   // Last read payload, right aligned
  output logic        rx_toggle_o  // Flips when a read payload is ready
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle link: clock parked low, select high
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    rx_word_o = 32'h0000_0000;
    rx_toggle_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame: ntx header bits from tx[39] down, then nrx read bits
  // ----------------------------------------------------------------
  task automatic frame(input logic [39:0] tx, input int ntx,
                       input int nrx);
    logic [31:0] rx;
    rx = 32'h0000_0000;
    cs_n_o = 1'b0;
    // Leave the device time to freeze its register picture
    #24;
    for (int i = 0; i < ntx + nrx; i++) begin
      if (i < ntx) mosi_o = tx[39-i];
      else mosi_o = ~mosi_o;
      #6 sck_o = 1'b1;
      // Undriven output reads as unknown, so it never passes
      if (i >= ntx) rx = {rx[30:0], miso_oe_i ? miso_i : 1'bx};
      #6 sck_o = 1'b0;
    end
    #6 cs_n_o = 1'b1;
    // Released data line does not keep its last value
    mosi_o = ~mosi_o;
    if (nrx > 0) begin
      rx_word_o = rx;
      rx_toggle_o = ~rx_toggle_o;
    end
    // Gap lets write events land before the next frame
    #40;
  endtask
endmodule

// ===== logic/flash_regs_defs.svh
// Command codes, field positions, reset values and counts of the block
`ifndef FLASH_REGS_DEFS_SVH
`define FLASH_REGS_DEFS_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define CMD_READ_STATUS_TWO 8'h07
`define CMD_BOOT_CFG_READ   8'h14
`define CMD_BOOT_CFG_WRITE  8'h15
`define CMD_BANK_READ       8'h16
`define CMD_BANK_WRITE      8'h17
`define CMD_BANK_ACCESS     8'hB9
`define CMD_WRITE_REGS      8'h01
`define CMD_ECC_STATUS_READ 8'h18

// ----------------------------------------------------------------------
// Link bit counts (index of the last bit of each header or payload, and the bit counter's ceiling)
// ----------------------------------------------------------------------
`define LAST_CMD_BIT    6'h07
`define LAST_BYTE_BIT   6'h0F
`define LAST_WORD_BIT   6'h27
`define LAST_ADDR3_BIT  6'h1F
`define LAST_ADDR4_BIT  6'h27
`define BIT_CNT_MAX     6'h3F

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define ECC_UNIT_LSB    4
`define BOOT_ALIGN_BITS 9
`define BOOT_CFG_RESET  32'h0000_0000
`define BANK_RESET      8'h00
`define STATUS_RESET    2'h0
`define ECC_FLAG_RESET  3'h0

`endif

// ===== logic/flash_regs_pkg.sv
// Types shared by the serial flash register group
package flash_regs_pkg;

  // Suspend flags of the second status register
  typedef struct packed {
    logic es;  // Erase suspended
    logic ps;  // Program suspended
  } susp_flags_t;

  // Boot-fetch configuration word
  typedef struct packed {
    logic [22:0] start_addr;   // Address bits 31..9
    logic [7:0]  start_delay;  // Delay cycles after select
    logic        enable;       // Fetch on reset
  } boot_cfg_t;

  // Bank address register
  typedef struct packed {
    logic       four_byte;  // Four-byte address enable
    logic [5:0] rsvd;       // Reserved, zero
    logic       bank_bit;   // Address bit 24
  } bank_reg_t;

  // Register write event passed from link to core clock
  typedef struct packed {
    logic [7:0]  cmd;
    logic [31:0] data;
  } link_evt_t;

  // Frozen register picture read by the link
  typedef struct packed {
    susp_flags_t susp;
    boot_cfg_t   boot;
    bank_reg_t   bank;
  } reg_snap_t;

endpackage

// ===== logic/sflash_regs.sv
// Status, boot-fetch, bank and ECC status registers behind a serial link
//
// Notes on behaviour
// - Command 07h returns status two, bits 7..2 zero
// - Bit 1 shows erase suspended, resets 0
// - Suspend flags are read-only, writes ignored
// - Bit 0 shows program suspended, resets 0
// - Boot config read 14h, written 15h
// - Enable bit starts boot fetch after resets
// - Bits 31..9 give 512-byte aligned start
// - Bits 8..1 give start delay cycles
// - Bank reached by B9h, 16h, 17h, 01h
// - Three-byte commands use bank as high bits
// - Four-byte mode ignores bank address
// - Four-byte enable cleared by every reset
// - Bank bit 0 is A24 when dense
// - Command 18h plus address reads unit status
// - One status per sixteen-byte unit
// - Bit 2 flags error in correction code
// - Bit 1 flags corrected data error
// - Bit 0 flags correction disabled, reset 0
// - Status bits 7..3 are don't care
`include "flash_regs_defs.svh"

module sflash_regs
  import flash_regs_pkg::*;
#(
  parameter int ECC_UNITS   = 16,  // Units visible to status reads
  parameter bit DENSITY_256 = 1'b1 // Bank bit 0 is live address
)(
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   hw_rst_n_i,
  input  wire logic                   sw_reset_i,
  input  wire logic                   sck_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   mosi_i,
  output logic                        miso_o,
  output logic                        miso_oe_o,
  input  wire logic                   erase_suspended_i,
  input  wire logic                   program_suspended_i,
  input  wire logic [ECC_UNITS*3-1:0] ecc_flags_i,
  output logic [7:0]                  addr_upper_o,
  output logic                        four_byte_addr_enable_o,
  output logic                        boot_fetch_go_o,
  output logic [31:0]                 boot_start_addr_o,
  output logic [7:0]                  boot_start_delay_o
);

  localparam int UIW = (ECC_UNITS > 1) ? $clog2(ECC_UNITS) : 1;

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic        hw_meta_reg;       // Hardware reset, first stage
  logic        hw_sync_reg;       // Hardware reset, synchronised
  logic        cs_meta_reg;       // Select, first stage
  logic        cs_sync_reg;       // Select, synchronised
  logic        evt_meta_reg;      // Event toggle, first stage
  logic        evt_sync_reg;      // Event toggle, synchronised
  logic        evt_seen_reg;      // Last toggle value taken
  logic        link_rst_n_reg;    // Link-side reset, made on core clock
  logic        vol_clr;           // Any of the three resets
  logic        evt_fire;          // New link event this cycle
  logic        bank_reg_access_cmd_pend_reg;     // Next register write hits the bank
  logic        boot_pend_reg;     // A reset awaits boot fetch
  susp_flags_t status_reg;        // Live suspend flags
  boot_cfg_t   boot_reg;          // Boot-fetch configuration
  bank_reg_t   bank_reg;          // Bank address register
  reg_snap_t   snap_reg;          // Picture frozen during frames
  logic [2:0]  ecc_snap [ECC_UNITS]; // Unit status frozen in frames
  logic [7:0]  bank_mask;         // Writable bank bits
  // Link domain
  logic [5:0]  bit_cnt_reg;       // Bits received this frame
  logic [31:0] shift_in_reg;      // Incoming bits
  logic [31:0] shift_in_next;     // Incoming bits with current one
  logic [7:0]  cmd_reg;           // Command byte of frame
  logic [7:0]  cmd_now;           // Command byte, valid from bit 8
  logic        rd_load_reg;       // Load read word on next fall
  logic [31:0] rd_word_reg;       // Word to shift out
  logic [31:0] out_sh_reg;        // Outgoing bits
  logic        evt_tgl_reg;       // Event toggle to core clock
  link_evt_t   evt_reg;           // Event payload, held till next
  logic [5:0]  ecc_last;          // Last header bit of ECC read
  logic [UIW-1:0] ecc_idx;        // Selected ECC unit

  // --------------------------------------------------------------------
  // Synchronisers and reset combination
  // --------------------------------------------------------------------

  // Two stages per level from outside, plus the toggle's last value
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hw_meta_reg  <= 1'b1;
      hw_sync_reg  <= 1'b1;
      cs_meta_reg  <= 1'b1;
      cs_sync_reg  <= 1'b1;
      evt_meta_reg <= 1'b0;
      evt_sync_reg <= 1'b0;
      evt_seen_reg <= 1'b0;
    end else begin
      hw_meta_reg  <= hw_rst_n_i;
      hw_sync_reg  <= hw_meta_reg;
      cs_meta_reg  <= cs_n_i;
      cs_sync_reg  <= cs_meta_reg;
      evt_meta_reg <= evt_tgl_reg;
      evt_sync_reg <= evt_meta_reg;
      evt_seen_reg <= evt_sync_reg;
    end
  end

  // Registered reset for the link side, so it is glitch free
  always_ff @(posedge mclk_i) begin
    link_rst_n_reg <= rst_n_i;
  end

  assign vol_clr  = !rst_n_i || !hw_sync_reg || sw_reset_i;
  assign evt_fire = evt_sync_reg ^ evt_seen_reg;
  assign bank_mask = {1'b1, 6'h00, DENSITY_256};

  // --------------------------------------------------------------------
  // Status two: suspend flags
  // --------------------------------------------------------------------

  // erase flag follows the core; program flag likewise
  // no write path reaches these flags
  always_ff @(posedge mclk_i) begin
    if (vol_clr) begin
      status_reg <= `STATUS_RESET;
    end else begin
      status_reg.es <= erase_suspended_i;
      status_reg.ps <= program_suspended_i;
    end
  end

  // --------------------------------------------------------------------
  // Boot-fetch configuration
  // --------------------------------------------------------------------

  // written by the boot write command; kept over warm resets
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      boot_reg <= `BOOT_CFG_RESET;
    end else if (evt_fire && evt_reg.cmd == `CMD_BOOT_CFG_WRITE) begin
      boot_reg <= evt_reg.data;
    end
  end

  // any reset arms the fetch; it starts when reset ends
  always_ff @(posedge mclk_i) begin
    if (vol_clr) begin
      boot_pend_reg   <= 1'b1;
      boot_fetch_go_o <= 1'b0;
    end else begin
      boot_pend_reg   <= 1'b0;
      boot_fetch_go_o <= boot_pend_reg && boot_reg.enable;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      boot_start_addr_o  <= 32'h0000_0000;
      boot_start_delay_o <= 8'h00;
    end else begin
      boot_start_addr_o  <= {boot_reg.start_addr, 9'h000};
      boot_start_delay_o <= boot_reg.start_delay;
    end
  end

  // --------------------------------------------------------------------
  // Bank address register
  // --------------------------------------------------------------------

  // bank written by 17h, or by 01h after B9h
  // volatile: every reset clears it; reserved bits kept zero
  always_ff @(posedge mclk_i) begin
    if (vol_clr) begin
      bank_reg      <= `BANK_RESET;
      bank_reg_access_cmd_pend_reg <= 1'b0;
    end else if (evt_fire) begin
      unique case (evt_reg.cmd)
        `CMD_BANK_ACCESS: bank_reg_access_cmd_pend_reg <= 1'b1;
        `CMD_BANK_WRITE:  bank_reg <= evt_reg.data[7:0] & bank_mask;
        `CMD_WRITE_REGS: begin
          // Only a write announced by the access command lands here
          if (bank_reg_access_cmd_pend_reg) begin
            bank_reg <= evt_reg.data[7:0] & bank_mask;
          end
          bank_reg_access_cmd_pend_reg <= 1'b0;
        end
        default:          bank_reg_access_cmd_pend_reg <= bank_reg_access_cmd_pend_reg;
      endcase
    end
  end

  // bank supplies the high bits; none in four-byte mode
  always_ff @(posedge mclk_i) begin
    if (vol_clr) begin
      addr_upper_o            <= 8'h00;
      four_byte_addr_enable_o <= 1'b0;
    end else begin
      addr_upper_o <= bank_reg.four_byte ? 8'h00
                                         : {7'h00, bank_reg.bank_bit};
      four_byte_addr_enable_o <= bank_reg.four_byte;
    end
  end

  // --------------------------------------------------------------------
  // Snapshot seen by the link
  // --------------------------------------------------------------------

  // Updated only between frames so the link reads stable words
  always_ff @(posedge mclk_i) begin
    if (vol_clr) begin
      snap_reg <= '0;
    end else if (cs_sync_reg) begin
      snap_reg <= {status_reg, boot_reg, bank_reg};
    end
  end

  // one status entry per unit of sixteen data bytes
  for (genvar u = 0; u < ECC_UNITS; u++) begin : g_ecc
    always_ff @(posedge mclk_i) begin
      if (vol_clr) begin
        ecc_snap[u] <= `ECC_FLAG_RESET;
      end else if (cs_sync_reg) begin
        ecc_snap[u] <= ecc_flags_i[u*3 +: 3];
      end
    end
  end

  // --------------------------------------------------------------------
  // Link side: receive
  // --------------------------------------------------------------------

  assign shift_in_next = {shift_in_reg[30:0], mosi_i};
  assign cmd_now  = (bit_cnt_reg == `LAST_CMD_BIT) ? shift_in_next[7:0]
                                                   : cmd_reg;
  assign ecc_last = snap_reg.bank.four_byte ? `LAST_ADDR4_BIT
                                            : `LAST_ADDR3_BIT;
  assign ecc_idx  = shift_in_next[`ECC_UNIT_LSB +: UIW];

  // Bit counting and command decode; frame end clears it
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_reg  <= 6'h00;
      shift_in_reg <= 32'h0000_0000;
      cmd_reg      <= 8'h00;
      rd_load_reg  <= 1'b0;
      rd_word_reg  <= 32'h0000_0000;
    end else begin
      shift_in_reg <= shift_in_next;
      rd_load_reg  <= 1'b0;
      if (bit_cnt_reg != `BIT_CNT_MAX) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
      if (bit_cnt_reg == `LAST_CMD_BIT) begin
        cmd_reg <= shift_in_next[7:0];
        unique case (shift_in_next[7:0])
          `CMD_READ_STATUS_TWO: begin
            rd_word_reg <= {6'h00, snap_reg.susp, 24'h000000};
            rd_load_reg <= 1'b1;
          end
          `CMD_BOOT_CFG_READ: begin
            rd_word_reg <= snap_reg.boot;
            rd_load_reg <= 1'b1;
          end
          `CMD_BANK_READ: begin
            rd_word_reg <= {snap_reg.bank, 24'h000000};
            rd_load_reg <= 1'b1;
          end
          default: rd_load_reg <= 1'b0;
        endcase
      end
      // unit status after the address; upper bits zero
      if (cmd_reg == `CMD_ECC_STATUS_READ && bit_cnt_reg == ecc_last) begin
        rd_word_reg <= {5'h00, ecc_snap[ecc_idx], 24'h000000};
        rd_load_reg <= 1'b1;
      end
    end
  end

  // Write events carried over by toggle; payload held until next
  always_ff @(posedge sck_i or negedge link_rst_n_reg) begin
    if (!link_rst_n_reg) begin
      evt_tgl_reg <= 1'b0;
      evt_reg     <= '0;
    end else if (!cs_n_i) begin
      if ((bit_cnt_reg == `LAST_CMD_BIT
           && cmd_now == `CMD_BANK_ACCESS)
          || (bit_cnt_reg == `LAST_BYTE_BIT
              && (cmd_reg == `CMD_BANK_WRITE
                  || cmd_reg == `CMD_WRITE_REGS))
          || (bit_cnt_reg == `LAST_WORD_BIT
              && cmd_reg == `CMD_BOOT_CFG_WRITE)) begin
        evt_reg.cmd  <= cmd_now;
        evt_reg.data <= shift_in_next;
        evt_tgl_reg  <= ~evt_tgl_reg;
      end
    end
  end

  // --------------------------------------------------------------------
  // Link side: transmit
  // --------------------------------------------------------------------

  // MSB first, driven on falling edges right after the header
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_sh_reg <= 32'h0000_0000;
      miso_o     <= 1'b0;
      miso_oe_o  <= 1'b0;
    end else if (rd_load_reg) begin
      out_sh_reg <= {rd_word_reg[30:0], 1'b0};
      miso_o     <= rd_word_reg[31];
      miso_oe_o  <= 1'b1;
    end else begin
      out_sh_reg <= {out_sh_reg[30:0], 1'b0};
      miso_o     <= out_sh_reg[31];
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------

  chk_erase_flag: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (erase_suspended_i && !vol_clr) |=> status_reg.es ##1 (snap_reg.susp.es
      || !$past(cs_sync_reg) || $past(vol_clr)))
    else $error("erase flag not reported");

  chk_prog_flag: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    vol_clr |=> !status_reg.ps && !status_reg.es)
    else $error("suspend flags not cleared by reset");

  chk_flags_ro: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (evt_fire && !vol_clr) |=> status_reg.ps == $past(program_suspended_i))
    else $error("write disturbed suspend flag");

  chk_boot_go: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    boot_fetch_go_o |-> $past(boot_reg.enable, 1) && $past(vol_clr, 2))
    else $error("boot fetch without enable or reset");

  chk_boot_align: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ##1 boot_start_addr_o[8:0] == 9'h000
      && boot_start_addr_o[31:9] == $past(boot_reg.start_addr))
    else $error("boot start address wrong");

  chk_boot_delay: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    ##1 boot_start_delay_o == $past(boot_reg.start_delay))
    else $error("boot delay wrong");

  chk_bank_high: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!bank_reg.four_byte && !vol_clr)
      |=> addr_upper_o == {7'h00, $past(bank_reg.bank_bit)})
    else $error("bank not used as high address");

  chk_bank_ignored: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    four_byte_addr_enable_o |-> addr_upper_o == 8'h00)
    else $error("bank used in four-byte mode");

  chk_fourbyte_clr: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sw_reset_i |=> !bank_reg.four_byte ##1 !four_byte_addr_enable_o)
    else $error("four-byte enable survived reset");

  chk_bank_rsvd: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    bank_reg.rsvd == 6'h00 && (DENSITY_256 || !bank_reg.bank_bit))
    else $error("reserved bank bits set");

  chk_stat_read: assert property (
    @(posedge sck_i) disable iff (cs_n_i)
    (bit_cnt_reg == `LAST_CMD_BIT
     && shift_in_next[7:0] == `CMD_READ_STATUS_TWO)
      |=> rd_load_reg && rd_word_reg[31:26] == 6'h00)
    else $error("status two read not loaded");

  chk_ecc_read: assert property (
    @(posedge sck_i) disable iff (cs_n_i)
    (cmd_reg == `CMD_ECC_STATUS_READ && bit_cnt_reg == ecc_last)
      |=> rd_load_reg && rd_word_reg[31:27] == 5'h00)
    else $error("unit status not loaded");

endmodule
